// ### design/oled_host_seq.sv
// host end: power-on/off sequencer and a single-transfer parallel bus master
// assumes a 100 MHz clock and pins wired to the display end through oled_link_if
`timescale 1ns/1ns
module oled_host_seq #(
  parameter int SETTLE_CYC = oled_seq_pkg::CORE_SETTLE_CYC,
  parameter int RST_CYC = oled_seq_pkg::RESET_PULSE_WIDTH_CYC,
  parameter int PANEL_WAIT_CYC = oled_seq_pkg::RESET_TO_PANEL_POWER_WAIT_CYC,
  parameter int OFF_WAIT_CYC = oled_seq_pkg::PANEL_TO_LOGIC_OFF_WAIT_CYC,
  parameter int STROBE_CYC = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_power_up,
  input wire logic i_power_down,
  input wire logic i_logic_supply_good,
  input wire logic [1:0] i_bus_style,
  input wire logic i_xfer_req,
  input wire logic i_xfer_read,
  input wire logic i_xfer_dc,
  input wire logic [17:0] i_xfer_data,
  output logic o_xfer_ack,
  output logic [17:0] o_xfer_rdata,
  output logic o_ready,
  output logic o_off,
  oled_link_if.host link
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum {
    OFF, SETTLE, RST_LOW, RST_HIGH, PANEL_ON, SEND_ON, READY, SEND_OFF, PANEL_OFF, LOGIC_OFF
  } seq_type;
  typedef enum {IDLE, STROBE, HOLD} bus_type;

  seq_type state, next_state;
  bus_type bstate, next_bstate;
  logic [31:0] cnt, next_cnt;
  logic [31:0] since_rst, next_since_rst;
  logic [7:0] scnt, next_scnt;
  logic good_s1, good_s2;
  logic [17:0] rd_s1, rd_s2;
  logic logic_on, next_logic_on, panel_on, next_panel_on, rst_low, next_rst_low;
  logic cmd_go, cmd_done;
  logic [7:0] cmd_code;
  logic b_read, next_b_read, b_dc, next_b_dc;
  logic [17:0] b_data, next_b_data, rdata, next_rdata;
  logic ack, next_ack, b_int, next_b_int;

  // the good flag comes from a supply monitor outside this clock domain
  always_ff @(posedge i_ref_clk) begin
    good_s1 <= i_logic_supply_good;
    good_s2 <= good_s1;
    rd_s1 <= link.bus_d;
    rd_s2 <= rd_s1;
  end

  // ----------------------------------------
  // power sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt + 32'h1;
    next_since_rst = (since_rst == 32'hFFFFFFFF) ? since_rst : since_rst + 32'h1;
    next_logic_on = logic_on;
    next_panel_on = panel_on;
    next_rst_low = rst_low;
    cmd_go = 1'b0;
    cmd_code = oled_seq_pkg::CMD_DISPLAY_ON;
    unique case (state)
      OFF: begin
        next_cnt = 32'h0;
        if (i_power_up) begin
          next_logic_on = 1'b1;
          next_state = SETTLE;
        end
      end
      SETTLE: if (!good_s2) next_cnt = 32'h0;
        else if (cnt >= SETTLE_CYC) begin
          next_rst_low = 1'b1;
          next_since_rst = 32'h0;
          next_cnt = 32'h0;
          next_state = RST_LOW;
        end
      RST_LOW: if (cnt >= RST_CYC) begin
          next_rst_low = 1'b0;
          next_state = RST_HIGH;
        end
      RST_HIGH: if (since_rst >= PANEL_WAIT_CYC) begin
          next_panel_on = 1'b1;
          next_state = PANEL_ON;
        end
      PANEL_ON: next_state = SEND_ON;
      SEND_ON: begin
        cmd_go = 1'b1;
        if (cmd_done) next_state = READY;
      end
      READY: if (i_power_down) next_state = SEND_OFF;
      SEND_OFF: begin
        cmd_go = 1'b1;
        cmd_code = oled_seq_pkg::CMD_DISPLAY_OFF;
        if (cmd_done) begin
          next_panel_on = 1'b0;
          next_cnt = 32'h0;
          next_state = PANEL_OFF;
        end
      end
      PANEL_OFF: if (cnt >= OFF_WAIT_CYC) begin
          next_logic_on = 1'b0;
          next_state = LOGIC_OFF;
        end
      LOGIC_OFF: next_state = OFF;
    endcase
    // a logic supply drop after SETTLE turns off both supplies, releases reset and drops back to OFF to wait for i_power_up
    if (logic_on && state != SETTLE && state != OFF && !good_s2) begin
      next_state = OFF;
      next_logic_on = 1'b0;
      next_panel_on = 1'b0;
      next_rst_low = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state <= OFF;
      cnt <= 32'h0;
      since_rst <= 32'h0;
      logic_on <= 1'b0;
      panel_on <= 1'b0;
      rst_low <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      since_rst <= next_since_rst;
      logic_on <= next_logic_on;
      panel_on <= next_panel_on;
      rst_low <= next_rst_low;
    end
  end

  // ----------------------------------------
  // bus master: one transfer, strobe held STROBE_CYC+1 cycles
  // ----------------------------------------
  logic user_go;
  assign user_go = (state == READY) && i_xfer_req;

  always_comb begin
    next_bstate = bstate;
    next_scnt = scnt + 8'h1;
    next_b_read = b_read;
    next_b_dc = b_dc;
    next_b_data = b_data;
    next_rdata = rdata;
    next_ack = 1'b0;
    next_b_int = b_int;
    unique case (bstate)
      IDLE: begin
        next_scnt = 8'h0;
        if (cmd_go) begin
          next_b_int = 1'b1;
          next_b_read = 1'b0;
          next_b_dc = 1'b0;
          next_b_data = {10'h000, cmd_code};
          next_bstate = STROBE;
        end else if (user_go) begin
          next_b_int = 1'b0;
          next_b_read = i_xfer_read;
          next_b_dc = i_xfer_dc;
          next_b_data = i_xfer_data;
          next_bstate = STROBE;
        end
      end
      STROBE: if (scnt >= STROBE_CYC[7:0]) begin
          if (b_read) next_rdata = rd_s2;
          next_scnt = 8'h0;
          next_bstate = HOLD;
        end
      HOLD: if (scnt >= STROBE_CYC[7:0]) begin
          next_ack = !b_int;
          next_bstate = IDLE;
        end
    endcase
  end
  assign cmd_done = (bstate == HOLD) && (scnt >= STROBE_CYC[7:0]) && b_int;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      bstate <= IDLE;
      scnt <= 8'h0;
      b_read <= 1'b0;
      b_dc <= 1'b0;
      b_data <= 18'h00000;
      rdata <= 18'h00000;
      ack <= 1'b0;
      b_int <= 1'b0;
    end else begin
      bstate <= next_bstate;
      scnt <= next_scnt;
      b_read <= next_b_read;
      b_dc <= next_b_dc;
      b_data <= next_b_data;
      rdata <= next_rdata;
      ack <= next_ack;
      b_int <= next_b_int;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  logic style6800, active;
  assign style6800 = (i_bus_style == oled_seq_pkg::STYLE_6800);
  assign active = (bstate == STROBE);
  assign link.logic_supply = logic_on;
  assign link.panel_supply = panel_on;
  assign link.hw_reset_low = !rst_low;
  assign link.bus_style_sel_lo = i_bus_style[0];
  assign link.bus_style_sel_hi = i_bus_style[1];
  assign link.cs_n = (bstate == IDLE);
  assign link.dc = b_dc;
  assign link.wr_sel = style6800 ? b_read : !(active && !b_read);
  assign link.en_rd = style6800 ? active : !(active && b_read);
  assign link.host_d = b_data;
  assign link.host_d_oe = (bstate != IDLE) && !b_read;
  assign o_xfer_ack = ack;
  assign o_xfer_rdata = rdata;
  assign o_ready = (state == READY);
  assign o_off = (state == OFF);
endmodule

// ### include/oled_seq_pkg.sv
// constants shared by the display-side and host-side ends of the power/reset link
// assumes a 100 MHz clock on both ends; all waits are counted in cycles of it
package oled_seq_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int CORE_SETTLE_US = 1000;
  localparam int RESET_PULSE_WIDTH_US = 100;
  localparam int RESET_TO_PANEL_POWER_WAIT_US = 100;
  localparam int DISPLAY_ON_DELAY_MS = 200;
  localparam int PANEL_TO_LOGIC_OFF_WAIT_MS = 100;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int CORE_SETTLE_CYC = CORE_SETTLE_US * CYC_PER_US;
  localparam int RESET_PULSE_WIDTH_CYC = RESET_PULSE_WIDTH_US * CYC_PER_US;
  localparam int RESET_TO_PANEL_POWER_WAIT_CYC = RESET_TO_PANEL_POWER_WAIT_US * CYC_PER_US;
  localparam int DISPLAY_ON_DELAY_CYC = DISPLAY_ON_DELAY_MS * 1000 * CYC_PER_US;
  localparam int PANEL_TO_LOGIC_OFF_WAIT_CYC = PANEL_TO_LOGIC_OFF_WAIT_MS * 1000 * CYC_PER_US;
  // ----------------------------------------
  // bus
  // ----------------------------------------
  localparam int DATA_W = 18;
  localparam logic [7:0] CMD_DISPLAY_ON = 8'hAF;
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
  // bus_style_sel_hi/lo: 2'b00 selects 6800 style, anything else 8080 style
  localparam logic [1:0] STYLE_6800 = 2'b00;
endpackage

// ### include/oled_link_if.sv
// pin bundle between the panel host and the display module
// the bench resolves the shared data wires from the two enables
`timescale 1ns/1ns
interface oled_link_if;
  logic logic_supply;
  logic panel_supply;
  logic hw_reset_low;
  logic bus_style_sel_lo;
  logic bus_style_sel_hi;
  logic cs_n;
  logic dc;
  logic wr_sel;
  logic en_rd;
  logic [17:0] host_d;
  logic host_d_oe;
  logic [17:0] dev_d;
  logic dev_d_oe;
  logic [17:0] bus_d;
  modport host (
    output logic_supply, panel_supply, hw_reset_low, bus_style_sel_lo, bus_style_sel_hi,
    output cs_n, dc, wr_sel, en_rd, host_d, host_d_oe,
    input bus_d
  );
  modport device (
    input logic_supply, panel_supply, hw_reset_low, bus_style_sel_lo, bus_style_sel_hi,
    input cs_n, dc, wr_sel, en_rd, bus_d,
    output dev_d, dev_d_oe
  );
endinterface

// ### design/oled_panel_dev.sv
// display end: reset pin handling, parallel port decode, display-on delay
// assumes pins arrive asynchronously from the host end through oled_link_if
`timescale 1ns/1ns
module oled_panel_dev #(
  parameter int RST_CYC = oled_seq_pkg::RESET_PULSE_WIDTH_CYC,
  parameter int ON_DELAY_CYC = oled_seq_pkg::DISPLAY_ON_DELAY_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [17:0] i_read_data,
  output logic o_panel_drive_outputs,
  output logic o_wr_strobe,
  output logic o_wr_dc,
  output logic [17:0] o_wr_data,
  output logic o_in_reset,
  oled_link_if.device link
);
  typedef enum {DARK, WAIT_ON, LIT} disp_type;
  disp_type dstate, next_dstate;
  logic [24:0] s1, s2, prev;
  logic [1:0] style_s1, style_s2;
  logic [31:0] rcnt, next_rcnt, dcnt, next_dcnt;
  logic regs_ok, next_regs_ok;
  logic wr_s, next_wr_s, dc_r, next_dc_r;
  logic [17:0] wd, next_wd;
  logic rd_act;

  // pin synchronisers; every read below uses s2 or style_s2, and the edge detects also use prev
  always_ff @(posedge i_ref_clk) begin
    s1 <= {link.hw_reset_low, link.logic_supply, link.panel_supply, link.cs_n,
           link.dc, link.wr_sel, link.en_rd, link.bus_d};
    s2 <= s1;
    prev <= s2;
    // style straps take the same two stages so they line up with the strobes
    style_s1 <= {link.bus_style_sel_hi, link.bus_style_sel_lo};
    style_s2 <= style_s1;
  end

  logic rst_pin_low, pwr, panel, cs_n, style6800, wr_edge, rd_lvl;
  assign rst_pin_low = !s2[24];
  assign pwr = s2[23];
  assign panel = s2[22];
  assign cs_n = s2[21];
  assign style6800 = (style_s2 == oled_seq_pkg::STYLE_6800);
  // 8080 writes on the rising edge of wr_sel, 6800 on the falling edge of en_rd
  assign wr_edge = !cs_n && (style6800 ? (prev[18] && !s2[18] && !s2[19])
                                       : (!prev[19] && s2[19]));
  assign rd_lvl = !cs_n && (style6800 ? (s2[18] && s2[19]) : !s2[18]);

  always_comb begin
    next_rcnt = rst_pin_low ? ((rcnt == 32'hFFFFFFFF) ? rcnt : rcnt + 32'h1) : 32'h0;
    next_regs_ok = regs_ok;
    if (rst_pin_low && rcnt >= RST_CYC) next_regs_ok = 1'b0;
    if (!rst_pin_low && !regs_ok) next_regs_ok = 1'b1;
    next_wr_s = wr_edge && regs_ok && !rst_pin_low;
    next_dc_r = wr_edge ? s2[20] : dc_r;
    next_wd = wr_edge ? s2[17:0] : wd;
    next_dstate = dstate;
    next_dcnt = dcnt + 32'h1;
    unique case (dstate)
      DARK: next_dcnt = 32'h0;
      WAIT_ON: if (dcnt >= ON_DELAY_CYC) next_dstate = LIT;
      LIT: next_dcnt = 32'h0;
    endcase
    if (wr_s && !dc_r && wd[7:0] == oled_seq_pkg::CMD_DISPLAY_ON && dstate == DARK) begin
      next_dstate = WAIT_ON;
      next_dcnt = 32'h0;
    end
    if (wr_s && !dc_r && wd[7:0] == oled_seq_pkg::CMD_DISPLAY_OFF) next_dstate = DARK;
    // panel outputs can never stay lit without both supplies or across reset
    if (rst_pin_low || !pwr || !panel) next_dstate = DARK;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      dstate <= DARK;
      rcnt <= 32'h0;
      dcnt <= 32'h0;
      regs_ok <= 1'b0;
      wr_s <= 1'b0;
      dc_r <= 1'b0;
      wd <= 18'h00000;
    end else begin
      dstate <= next_dstate;
      rcnt <= next_rcnt;
      dcnt <= next_dcnt;
      regs_ok <= next_regs_ok;
      wr_s <= next_wr_s;
      dc_r <= next_dc_r;
      wd <= next_wd;
    end
  end

  assign rd_act = rd_lvl && regs_ok;
  assign o_panel_drive_outputs = (dstate == LIT);
  assign o_wr_strobe = wr_s;
  assign o_wr_dc = dc_r;
  assign o_wr_data = wd;
  assign o_in_reset = !regs_ok;
  assign link.dev_d = i_read_data;
  assign link.dev_d_oe = rd_act;
endmodule

// ### tb/oled_link_sva.sv
// pin-level assertions on the host/display link
// assumes the bench wires the link signals straight in
`timescale 1ns/1ns
module oled_link_sva #(
  parameter int SETTLE_CYC = 20,
  parameter int RST_CYC = 10,
  parameter int PANEL_WAIT_CYC = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic logic_supply,
  input wire logic panel_supply,
  input wire logic hw_reset_low,
  input wire logic bus_style_sel_lo,
  input wire logic bus_style_sel_hi,
  input wire logic cs_n,
  input wire logic wr_sel,
  input wire logic en_rd,
  input wire logic [17:0] host_d,
  input wire logic host_d_oe,
  input wire logic dev_d_oe
);
  // ----
  // cycle counters
  // ----
  int sup_cnt;
  int low_cnt;
  int since_cnt;
  logic s8080;
  assign s8080 = {bus_style_sel_hi, bus_style_sel_lo} != oled_seq_pkg::STYLE_6800;
  // since_cnt keeps running after the pin rises, so the panel supply can still be timed
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      sup_cnt <= 0;
      low_cnt <= 0;
      since_cnt <= 0;
    end else begin
      sup_cnt <= logic_supply ? sup_cnt + 1 : 0;
      low_cnt <= hw_reset_low ? 0 : low_cnt + 1;
      since_cnt <= !logic_supply ? 0 : (!hw_reset_low || since_cnt != 0) ? since_cnt + 1 : 0;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  settle_wait_a:
    assert property ($fell(hw_reset_low) |-> sup_cnt >= SETTLE_CYC) else $error("early reset");
  reset_width_a:
    assert property ($rose(hw_reset_low) |-> low_cnt >= RST_CYC) else $error("short reset");
  reset_release_a:
    assert property ($fell(hw_reset_low) |-> ##[1:64] hw_reset_low) else $error("reset stuck");
  panel_wait_a:
    assert property ($rose(panel_supply) |-> logic_supply && since_cnt >= PANEL_WAIT_CYC)
      else $error("panel supply too early");
  supply_order_a:
    assert property ($fell(logic_supply) |-> !panel_supply) else $error("logic off first");
  bus_quiet_a:
    assert property (!panel_supply |-> cs_n) else $error("transfer while unpowered");
  no_contend_a:
    assert property (host_d_oe |-> !dev_d_oe) else $error("both ends drive data");
  wr_hold_a:
    assert property (host_d_oe && $past(host_d_oe) |-> $stable(host_d)) else $error("data moved");
  one_strobe_a:
    assert property (s8080 && !cs_n |-> wr_sel || en_rd) else $error("both strobes low");
  dev_drive_a:
    assert property (dev_d_oe |-> !cs_n && hw_reset_low) else $error("stray device drive");
endmodule

// ### tb/oled_power_reset_sequencer_tb.sv
// bench: host and display ends joined by the link, checker beside it
// assumes shortened waits; expected results are noted in queues
`timescale 1ns/1ns
module oled_power_reset_sequencer_tb;
  localparam int SETTLE = 20;
  localparam int RST = 10;
  localparam int PWAIT = 10;
  localparam int OFFW = 20;
  localparam int ONDLY = 50;
  localparam int STROBE = 16;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic up = 1'b0, down = 1'b0, good = 1'b0, drop = 1'b0, req = 1'b0, rd = 1'b0, dc = 1'b0;
  logic [1:0] style = 2'b01;
  logic [17:0] wdata = 18'h0, rdata_in = 18'h0, rdata, wd, m;
  logic ack, ready, off, lit, wstb, wdc, in_rst, psup, lsup, rpin;
  logic saw_rst = 1'b0;
  logic [18:0] e;
  logic [18:0] wq[$];
  logic [18:0] aq[$];
  int fails = 0, samples_checked = 0, cyc = 0, n, s, w, seed = 32'hB78EAC51;
  oled_link_if link();
  // released data lines show a moving pattern, never the last value
  assign link.bus_d = link.host_d_oe ? link.host_d :
    (link.dev_d_oe ? link.dev_d : cyc[17:0] ^ 18'h2AAAA);
  assign psup = link.panel_supply;
  assign lsup = link.logic_supply;
  assign rpin = link.hw_reset_low;
  oled_host_seq #(.SETTLE_CYC(SETTLE), .RST_CYC(RST), .PANEL_WAIT_CYC(PWAIT),
    .OFF_WAIT_CYC(OFFW), .STROBE_CYC(STROBE)) i_oled_host_seq (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_power_up(up), .i_power_down(down),
    .i_logic_supply_good(good), .i_bus_style(style), .i_xfer_req(req), .i_xfer_read(rd),
    .i_xfer_dc(dc), .i_xfer_data(wdata), .o_xfer_ack(ack), .o_xfer_rdata(rdata),
    .o_ready(ready), .o_off(off), .link(link.host));
  oled_panel_dev #(.RST_CYC(RST), .ON_DELAY_CYC(ONDLY)) i_oled_panel_dev (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_read_data(rdata_in),
    .o_panel_drive_outputs(lit), .o_wr_strobe(wstb), .o_wr_dc(wdc), .o_wr_data(wd),
    .o_in_reset(in_rst), .link(link.device));
  oled_link_sva #(.SETTLE_CYC(SETTLE), .RST_CYC(RST), .PANEL_WAIT_CYC(PWAIT)) i_oled_link_sva (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .logic_supply(link.logic_supply),
    .panel_supply(link.panel_supply), .hw_reset_low(link.hw_reset_low),
    .bus_style_sel_lo(link.bus_style_sel_lo), .bus_style_sel_hi(link.bus_style_sel_hi),
    .cs_n(link.cs_n), .wr_sel(link.wr_sel), .en_rd(link.en_rd), .host_d(link.host_d),
    .host_d_oe(link.host_d_oe), .dev_d_oe(link.dev_d_oe));
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // ----
  // supply monitor and timeout
  // ----
  always @(posedge i_ref_clk) begin
    #1;
    good = link.logic_supply & ~drop;
  end
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      conclude();
    end
  end
  // ----
  // result watcher
  // ----
  always @(posedge i_ref_clk) begin
    // registered outputs are read after the edge that launches them has settled
    #1;
    if (in_rst === 1'b1) saw_rst = 1'b1;
    if (wstb === 1'b1) begin
      if (wq.size() == 0) miss("unexpected write");
      else cmp_v({wdc, wd}, wq.pop_front(), "write word");
    end
    if (ack === 1'b1) begin
      if (aq.size() == 0) miss("unexpected ack");
      else begin
        e = aq.pop_front();
        if (e[18]) cmp_v({1'b1, rdata}, e, "read word");
      end
    end
  end
  task automatic miss(input string t);
    fails++;
    $display("[FAIL] %0t %s", $time, t);
  endtask
  task automatic cmp_v(input logic [18:0] g, input logic [18:0] x, input string t);
    samples_checked++;
    if (g !== x) miss(t);
  endtask
  task automatic cmp_b(input logic g, input logic x, input string t);
    samples_checked++;
    if (g !== x) miss(t);
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait_on(ref logic sig, input logic v, output int c);
    c = 0;
    while (sig !== v && c < 500) begin
      step(1);
      c++;
    end
    if (sig !== v) miss("wait ran out");
  endtask
  task automatic xfer(input logic r, input logic d, input logic [17:0] v);
    rd = r;
    dc = d;
    wdata = v;
    rdata_in = 18'($random(seed));
    if (!r) wq.push_back({d, v});
    aq.push_back({r, r ? rdata_in : v});
    req = 1'b1;
    step(1);
    req = 1'b0;
    wait_on(ack, 1'b1, n);
    step(1);
  endtask
  task automatic power_on();
    saw_rst = 1'b0;
    wq.push_back({1'b0, 18'h000AF});
    up = 1'b1;
    step(1);
    up = 1'b0;
    wait_on(rpin, 1'b0, n);
    wait_on(rpin, 1'b1, n);
    cmp_b(n >= RST, 1'b1, "reset pulse");
    wait_on(ready, 1'b1, n);
    cmp_b(psup && wq.size() == 0, 1'b1, "display-on after panel supply");
    cmp_b(saw_rst, 1'b1, "registers reset by pulse");
    cmp_b(in_rst, 1'b0, "registers out of reset");
    cmp_b(lit, 1'b0, "lit too soon");
    wait_on(lit, 1'b1, n);
    cmp_b(n >= ONDLY - 2 * STROBE && n <= ONDLY, 1'b1, "on delay");
  endtask
  task automatic power_down();
    wq.push_back({1'b0, 18'h000AE});
    down = 1'b1;
    step(1);
    down = 1'b0;
    wait_on(psup, 1'b0, n);
    cmp_b(wq.size() == 0, 1'b1, "off command first");
    cmp_b(lit, 1'b0, "dark after off");
    wait_on(lsup, 1'b0, n);
    cmp_b(n >= OFFW, 1'b1, "logic off wait");
    wait_on(off, 1'b1, n);
  endtask
  task automatic conclude();
    $display("checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    step(20);
    cmp_b(in_rst, 1'b1, "held in reset");
    i_resetn = 1'b1;
    step(2);
    power_on();
    for (s = 0; s < 4; s++) begin
      for (w = 0; w < 3; w++) begin
        style = s[1:0];
        m = (w == 0) ? 18'h000FF : (w == 1) ? 18'h0FFFF : 18'h3FFFF;
        xfer(1'b0, 1'($random(seed)), 18'($random(seed)) & m);
        xfer(1'b1, 1'b1, 18'h0);
      end
    end
    power_down();
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(40);
    power_on();
    drop = 1'b1;
    wait_on(off, 1'b1, n);
    step(4);
    cmp_b(psup | lit, 1'b0, "dropped supply");
    drop = 1'b0;
    power_on();
    power_down();
    cmp_b(wq.size() == 0 && aq.size() == 0, 1'b1, "all results seen");
    conclude();
  end
endmodule
